// [iex_consts.svh]
`ifndef IEX_CONSTS_SVH
`define IEX_CONSTS_SVH
// Instruction identifiers
`define IEX_OP_REG_MOVE 8'h01
`define IEX_OP_LIT_MOVE 8'h02
`define IEX_OP_LOAD_IND 8'h03
`define IEX_OP_STORE_IND 8'h04
`define IEX_OP_COMPARE 8'h05
`define IEX_OP_COND_BRANCH 8'h06
`define IEX_OP_SUB_BRANCH 8'h07
`define IEX_OP_ROUTINE_EXIT 8'h08
`define IEX_OP_ARITH 8'h09
`define IEX_OP_LOGIC 8'h0A
`define IEX_OP_SOFT_INT 8'h0B
`define IEX_OP_PAR_BLOCK 8'h0C
`define IEX_OP_IDLE 8'h0D
// Opcode word field positions
`define IEX_F_ID_LSB 0
`define IEX_F_SRC_LSB 8
`define IEX_F_TGT_LSB 16
// Register identifiers
`define IEX_RID_IP 8'h00
`define IEX_RID_LINK 8'h1C
`define IEX_RID_CMP 8'h24
`define IEX_RID_LGC 8'h28
`define IEX_RID_ARS 8'h2C
`define IEX_RID_GP_BASE 8'h30
`define IEX_RID_FP_BASE 8'h60
`define IEX_RID_LAST 8'h6C
`define IEX_RID_NULL 8'h00
// Field positions in control registers
`define IEX_CMP_RES_BIT 0
`define IEX_ARS_CLR_LO 6
`define IEX_ARS_CLR_HI 7
// Reset values and steps
`define IEX_IP_RESET 32'h0000_0000
`define IEX_LINK_RESET 32'h0000_0000
`define IEX_WORD_STEP 32'h0000_0004
`define IEX_ALIGN_MASK 32'h0000_0003
`endif

// [iex_pkg.sv]
package iex_pkg;
  typedef enum logic [3:0] {
    IEX_S_FETCH = 4'b0000,
    IEX_S_DECODE = 4'b0001,
    IEX_S_EXT1 = 4'b0010,
    IEX_S_EXT2 = 4'b0011,
    IEX_S_MREAD = 4'b0100,
    IEX_S_EXEC = 4'b0101,
    IEX_S_MWRITE = 4'b0110,
    IEX_S_FAULT = 4'b0111
  } iex_state_e;

  typedef struct packed {
    logic req;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } iex_mem_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } iex_mem_rsp_s;

  typedef struct packed {
    logic [7:0] tgt;
    logic [7:0] src;
    logic [7:0] id;
  } iex_opcode_s;
endpackage : iex_pkg

// [iex_alu.sv]
`timescale 1ns/10ps
`include "iex_consts.svh"
// ****************************************
// Arithmetic, logic and compare unit
// ****************************************
module iex_alu (
  input wire logic [31:0] i_src,
  input wire logic [31:0] i_tgt,
  input wire logic [31:0] i_arith_sel,
  input wire logic [31:0] i_logic_sel,
  input wire logic [31:0] i_cmp_sel,
  output logic [31:0] o_arith,
  output logic [31:0] o_logic,
  output logic o_cmp
);
  // Selector codes sit in bits 3:1; the selector registers' inner meaning is free
  always_comb
  begin
    unique case (i_arith_sel[3:1])
      3'h0: o_arith = i_tgt + i_src;
      3'h1: o_arith = i_tgt - i_src;
      3'h2: o_arith = 32'(i_tgt * i_src);
      3'h3: o_arith = i_tgt << i_src[4:0];
      3'h4: o_arith = i_tgt >> i_src[4:0];
      3'h5: o_arith = i_tgt + 32'h0000_0001;
      3'h6: o_arith = i_tgt - 32'h0000_0001;
      3'h7: o_arith = 32'h0000_0000 - i_tgt;
    endcase
    unique case (i_logic_sel[3:1])
      3'h0: o_logic = i_tgt & i_src;
      3'h1: o_logic = i_tgt | i_src;
      3'h2: o_logic = i_tgt ^ i_src;
      3'h3: o_logic = ~i_src;
      3'h4: o_logic = ~(i_tgt & i_src);
      3'h5: o_logic = ~(i_tgt | i_src);
      3'h6: o_logic = ~(i_tgt ^ i_src);
      3'h7: o_logic = i_src;
    endcase
    unique case (i_cmp_sel[3:1])
      3'h0: o_cmp = (i_src == i_tgt);
      3'h1: o_cmp = (i_src != i_tgt);
      3'h2: o_cmp = (i_src < i_tgt);
      3'h3: o_cmp = (i_src <= i_tgt);
      3'h4: o_cmp = (i_src > i_tgt);
      3'h5: o_cmp = (i_src >= i_tgt);
      3'h6: o_cmp = ($signed(i_src) < $signed(i_tgt));
      3'h7: o_cmp = ($signed(i_src) > $signed(i_tgt));
    endcase
  end
endmodule : iex_alu

// [iex_core.sv]
`timescale 1ns/10ps
`include "iex_consts.svh"
// How it works
// - register_move copies source register into target register or memory word
// - literal_move writes stream literal into target register or memory
// - load_indirect reads memory at source address (register value or extension word) into target
// - store_indirect writes source register to address held in target register
// - compare_op applies selected comparison, result lands in comparator_reg bit 0
// - compare_op clears the result bit before storing the new outcome
// - conditional_branch loads instr_pointer with source address or register value
// - conditional_branch does nothing when comparator_reg bit 0 is zero
// - subroutine_branch pushes next address at link_stack_reg, then jumps
// - routine_exit reloads instr_pointer from last pushed link, then pops it
// - arithmetic_op applies arith_select_reg operation, result into target
// - arithmetic_op clears bits 6 and 7 of arith_select_reg
// - logic_op applies logic_select_reg operation, result into target
// - soft_interrupt raises interrupt whose identifier is the source literal
// - parallel_block hands the source-to-target address range for parallel run
// - parallel_block faults if end not above start or range misaligned
// - idle_op only advances instr_pointer by 4
// - id from low byte, source from next byte, target from byte above
// - register ids step by four: control 0x00, general 0x30, float 0x60
module iex_core (
  input wire logic i_clock,
  input wire logic i_rst_b,
  output iex_pkg::iex_mem_req_s o_mem_req,
  input wire iex_pkg::iex_mem_rsp_s i_mem_rsp,
  output logic o_soft_int,
  output logic [7:0] o_soft_int_id,
  output logic o_par_block,
  output logic [31:0] o_par_start,
  output logic [31:0] o_par_end,
  output logic o_illegal_fault,
  output logic [31:0] o_fault_ip
);
  // ****************************************
  // Helpers
  // ****************************************
  // A null id in an operand byte means the operand is a memory word, not a register
  function automatic logic is_reg(input logic [7:0] rid);
    is_reg = (rid != `IEX_RID_NULL) && (rid[1:0] == 2'b00) && (rid <= `IEX_RID_LAST);
  endfunction : is_reg

  function automatic logic [4:0] rix(input logic [7:0] rid);
    rix = rid[6:2];
  endfunction : rix

  // ****************************************
  // State
  // ****************************************
  iex_pkg::iex_state_e state_r, state_nxt;
  logic [31:0] ip_r, ip_nxt;
  logic [31:0] regs_r [0:27];
  logic [31:0] regs_nxt [0:27];
  iex_pkg::iex_opcode_s op_r, op_nxt;
  logic [31:0] ext1_r, ext1_nxt;
  logic [31:0] ext2_r, ext2_nxt;
  logic [31:0] mdata_r, mdata_nxt;
  logic [31:0] waddr_r, waddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [31:0] link_r, link_nxt;
  logic [31:0] step_r, step_nxt;
  iex_pkg::iex_mem_req_s req_r, req_nxt;
  logic sint_r, sint_nxt;
  logic [7:0] sint_id_r, sint_id_nxt;
  logic par_r, par_nxt;
  logic [31:0] par_s_r, par_s_nxt;
  logic [31:0] par_e_r, par_e_nxt;
  logic flt_r, flt_nxt;
  logic [31:0] fip_r, fip_nxt;

  logic src_is_reg, tgt_is_reg;
  logic [31:0] src_val, tgt_val, src_addr, tgt_addr;
  logic [31:0] alu_arith, alu_logic;
  logic alu_cmp;
  logic [1:0] ext_need;
  logic need_mread;
  logic known_id;

  assign src_is_reg = is_reg(op_r.src);
  assign tgt_is_reg = is_reg(op_r.tgt);
  assign src_val = (op_r.src == `IEX_RID_IP) ? ip_r : regs_r[rix(op_r.src)];
  assign tgt_val = (op_r.tgt == `IEX_RID_IP) ? ip_r : regs_r[rix(op_r.tgt)];
  // Source address from register or first extension word
  assign src_addr = src_is_reg ? src_val : ext1_r;
  // Target memory address is the first extension word when the source is a register, else the last
  assign tgt_addr = src_is_reg ? ext1_r : ((ext_need == 2'd2) ? ext2_r : ext1_r);

  iex_alu u_alu (
    .i_src(src_val),
    .i_tgt(tgt_val),
    .i_arith_sel(regs_r[rix(`IEX_RID_ARS)]),
    .i_logic_sel(regs_r[rix(`IEX_RID_LGC)]),
    .i_cmp_sel(regs_r[rix(`IEX_RID_CMP)]),
    .o_arith(alu_arith),
    .o_logic(alu_logic),
    .o_cmp(alu_cmp)
  );

  // ****************************************
  // Decode of operand shapes
  // ****************************************
  always_comb
  begin
    ext_need = 2'd0;
    need_mread = 1'b0;
    known_id = 1'b1;
    unique case (op_r.id)
      `IEX_OP_REG_MOVE: ext_need = tgt_is_reg ? 2'd0 : 2'd1;
      `IEX_OP_LIT_MOVE, `IEX_OP_LOAD_IND:
      begin
        ext_need = tgt_is_reg ? 2'd1 : 2'd2;
        if (src_is_reg && op_r.id == `IEX_OP_LOAD_IND)
        begin
          ext_need = tgt_is_reg ? 2'd0 : 2'd1;
        end
        need_mread = (op_r.id == `IEX_OP_LOAD_IND);
      end
      `IEX_OP_COND_BRANCH, `IEX_OP_SUB_BRANCH: ext_need = src_is_reg ? 2'd0 : 2'd1;
      `IEX_OP_PAR_BLOCK: ext_need = 2'((src_is_reg ? 0 : 1) + (tgt_is_reg ? 0 : 1));
      `IEX_OP_ROUTINE_EXIT: need_mread = 1'b1;
      `IEX_OP_STORE_IND, `IEX_OP_COMPARE, `IEX_OP_ARITH, `IEX_OP_LOGIC,
      `IEX_OP_SOFT_INT, `IEX_OP_IDLE: ext_need = 2'd0;
      default: known_id = 1'b0;
    endcase
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb
  begin
    state_nxt = state_r;
    ip_nxt = ip_r;
    regs_nxt = regs_r;
    op_nxt = op_r;
    ext1_nxt = ext1_r;
    ext2_nxt = ext2_r;
    mdata_nxt = mdata_r;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    link_nxt = link_r;
    step_nxt = step_r;
    req_nxt = req_r;
    sint_nxt = 1'b0;
    sint_id_nxt = sint_id_r;
    par_nxt = 1'b0;
    par_s_nxt = par_s_r;
    par_e_nxt = par_e_r;
    flt_nxt = 1'b0;
    fip_nxt = fip_r;
    unique case (state_r)
      iex_pkg::IEX_S_FETCH:
      begin
        req_nxt = '{req: 1'b1, wr: 1'b0, addr: ip_r, wdata: 32'h0000_0000};
        if (req_r.req && i_mem_rsp.ack)
        begin
          req_nxt.req = 1'b0;
          op_nxt = iex_pkg::iex_opcode_s'(i_mem_rsp.rdata[23:0]);
          state_nxt = iex_pkg::IEX_S_DECODE;
        end
      end
      iex_pkg::IEX_S_DECODE:
      begin
        step_nxt = `IEX_WORD_STEP;
        if (!known_id)
        begin
          fip_nxt = ip_r;
          state_nxt = iex_pkg::IEX_S_FAULT;
        end
        else if (ext_need != 2'd0)
        begin
          state_nxt = iex_pkg::IEX_S_EXT1;
        end
        else if (need_mread)
        begin
          state_nxt = iex_pkg::IEX_S_MREAD;
        end
        else
        begin
          state_nxt = iex_pkg::IEX_S_EXEC;
        end
      end
      iex_pkg::IEX_S_EXT1, iex_pkg::IEX_S_EXT2:
      begin
        req_nxt = '{req: 1'b1, wr: 1'b0, addr: ip_r + step_r, wdata: 32'h0000_0000};
        if (req_r.req && i_mem_rsp.ack)
        begin
          req_nxt.req = 1'b0;
          step_nxt = step_r + `IEX_WORD_STEP;
          if (state_r == iex_pkg::IEX_S_EXT1)
          begin
            ext1_nxt = i_mem_rsp.rdata;
          end
          else
          begin
            ext2_nxt = i_mem_rsp.rdata;
          end
          if (state_r == iex_pkg::IEX_S_EXT1 && ext_need == 2'd2)
          begin
            state_nxt = iex_pkg::IEX_S_EXT2;
          end
          else
          begin
            state_nxt = need_mread ? iex_pkg::IEX_S_MREAD : iex_pkg::IEX_S_EXEC;
          end
        end
      end
      iex_pkg::IEX_S_MREAD:
      begin
        // Return address lives at the word just below link_stack_reg
        req_nxt.req = 1'b1;
        req_nxt.wr = 1'b0;
        req_nxt.addr = (op_r.id == `IEX_OP_ROUTINE_EXIT) ? link_r - `IEX_WORD_STEP : src_addr;
        if (req_r.req && i_mem_rsp.ack)
        begin
          req_nxt.req = 1'b0;
          mdata_nxt = i_mem_rsp.rdata;
          state_nxt = iex_pkg::IEX_S_EXEC;
        end
      end
      iex_pkg::IEX_S_EXEC:
      begin
        ip_nxt = ip_r + step_r;
        state_nxt = iex_pkg::IEX_S_FETCH;
        unique case (op_r.id)
          `IEX_OP_REG_MOVE, `IEX_OP_LIT_MOVE, `IEX_OP_LOAD_IND:
          begin
            wdata_nxt = (op_r.id == `IEX_OP_REG_MOVE) ? src_val :
                        (op_r.id == `IEX_OP_LIT_MOVE) ? ext1_r : mdata_r;
            if (tgt_is_reg && op_r.tgt != `IEX_RID_IP)
            begin
              regs_nxt[rix(op_r.tgt)] = (op_r.id == `IEX_OP_REG_MOVE) ? src_val :
                                        (op_r.id == `IEX_OP_LIT_MOVE) ? ext1_r : mdata_r;
            end
            else if (!tgt_is_reg)
            begin
              waddr_nxt = tgt_addr;
              state_nxt = iex_pkg::IEX_S_MWRITE;
            end
          end
          `IEX_OP_STORE_IND:
          begin
            waddr_nxt = tgt_val;
            wdata_nxt = src_val;
            state_nxt = iex_pkg::IEX_S_MWRITE;
          end
          `IEX_OP_COMPARE:
          begin
            // Clear then set in one step: the old result never leaks through
            regs_nxt[rix(`IEX_RID_CMP)][`IEX_CMP_RES_BIT] = 1'b0;
            regs_nxt[rix(`IEX_RID_CMP)][`IEX_CMP_RES_BIT] = alu_cmp;
          end
          `IEX_OP_COND_BRANCH:
          begin
            if (regs_r[rix(`IEX_RID_CMP)][`IEX_CMP_RES_BIT])
            begin
              ip_nxt = src_addr;
            end
          end
          `IEX_OP_SUB_BRANCH:
          begin
            waddr_nxt = link_r;
            wdata_nxt = ip_r + step_r;
            link_nxt = link_r + `IEX_WORD_STEP;
            ip_nxt = src_addr;
            state_nxt = iex_pkg::IEX_S_MWRITE;
          end
          `IEX_OP_ROUTINE_EXIT:
          begin
            ip_nxt = mdata_r;
            link_nxt = link_r - `IEX_WORD_STEP;
          end
          `IEX_OP_ARITH:
          begin
            if (tgt_is_reg && op_r.tgt != `IEX_RID_IP)
            begin
              regs_nxt[rix(op_r.tgt)] = alu_arith;
            end
            regs_nxt[rix(`IEX_RID_ARS)][`IEX_ARS_CLR_HI:`IEX_ARS_CLR_LO] = 2'b00;
          end
          `IEX_OP_LOGIC:
          begin
            if (tgt_is_reg && op_r.tgt != `IEX_RID_IP)
            begin
              regs_nxt[rix(op_r.tgt)] = alu_logic;
            end
          end
          `IEX_OP_SOFT_INT:
          begin
            // The pointer stays on the interrupting instruction for the handler
            ip_nxt = ip_r;
            sint_nxt = 1'b1;
            sint_id_nxt = op_r.src;
          end
          `IEX_OP_PAR_BLOCK:
          begin
            par_s_nxt = src_is_reg ? src_val : ext1_r;
            par_e_nxt = tgt_is_reg ? tgt_val : (src_is_reg ? ext1_r : ext2_r);
            if ((par_e_nxt <= par_s_nxt) || (((par_s_nxt | par_e_nxt) & `IEX_ALIGN_MASK) != 32'h0000_0000))
            begin
              ip_nxt = ip_r;
              fip_nxt = ip_r;
              state_nxt = iex_pkg::IEX_S_FAULT;
            end
            else
            begin
              par_nxt = 1'b1;
            end
          end
          default: ip_nxt = ip_r + step_r;
        endcase
        // A move or result aimed at link_stack_reg must reach the stack pointer as well
        if (op_r.id == `IEX_OP_SUB_BRANCH || op_r.id == `IEX_OP_ROUTINE_EXIT)
        begin
          regs_nxt[rix(`IEX_RID_LINK)] = link_nxt;
        end
        else
        begin
          link_nxt = regs_nxt[rix(`IEX_RID_LINK)];
        end
      end
      iex_pkg::IEX_S_MWRITE:
      begin
        req_nxt = '{req: 1'b1, wr: 1'b1, addr: waddr_r, wdata: wdata_r};
        if (req_r.req && i_mem_rsp.ack)
        begin
          req_nxt.req = 1'b0;
          state_nxt = iex_pkg::IEX_S_FETCH;
        end
      end
      iex_pkg::IEX_S_FAULT:
      begin
        // Core parks here until reset; fault routing is handled elsewhere
        flt_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_r <= iex_pkg::IEX_S_FETCH;
      ip_r <= `IEX_IP_RESET;
      for (int k = 0; k < 28; k++)
      begin
        regs_r[k] <= 32'h0000_0000;
      end
      op_r <= '0;
      ext1_r <= 32'h0000_0000;
      ext2_r <= 32'h0000_0000;
      mdata_r <= 32'h0000_0000;
      waddr_r <= 32'h0000_0000;
      wdata_r <= 32'h0000_0000;
      link_r <= `IEX_LINK_RESET;
      step_r <= `IEX_WORD_STEP;
      req_r <= '0;
      sint_r <= 1'b0;
      sint_id_r <= 8'h00;
      par_r <= 1'b0;
      par_s_r <= 32'h0000_0000;
      par_e_r <= 32'h0000_0000;
      flt_r <= 1'b0;
      fip_r <= 32'h0000_0000;
    end
    else
    begin
      state_r <= state_nxt;
      ip_r <= ip_nxt;
      regs_r <= regs_nxt;
      op_r <= op_nxt;
      ext1_r <= ext1_nxt;
      ext2_r <= ext2_nxt;
      mdata_r <= mdata_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
      link_r <= link_nxt;
      step_r <= step_nxt;
      req_r <= req_nxt;
      sint_r <= sint_nxt;
      sint_id_r <= sint_id_nxt;
      par_r <= par_nxt;
      par_s_r <= par_s_nxt;
      par_e_r <= par_e_nxt;
      flt_r <= flt_nxt;
      fip_r <= fip_nxt;
    end
  end

  assign o_mem_req = req_r;
  assign o_soft_int = sint_r;
  assign o_soft_int_id = sint_id_r;
  assign o_par_block = par_r;
  assign o_par_start = par_s_r;
  assign o_par_end = par_e_r;
  assign o_illegal_fault = flt_r;
  assign o_fault_ip = fip_r;
endmodule : iex_core

// [iex_core_sva.sv]
`timescale 1ns/10ps
// ****************************************
// Port checker for the execution core
// ****************************************
module iex_core_sva (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire iex_pkg::iex_mem_req_s o_mem_req,
  input wire iex_pkg::iex_mem_rsp_s i_mem_rsp,
  input wire logic o_soft_int,
  input wire logic [7:0] o_soft_int_id,
  input wire logic o_par_block,
  input wire logic [31:0] o_par_start,
  input wire logic [31:0] o_par_end,
  input wire logic o_illegal_fault,
  input wire logic [31:0] o_fault_ip
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);

  property p_req_hold;
    o_mem_req.req && !i_mem_rsp.ack |=> o_mem_req.req && $stable(o_mem_req);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("memory request moved before ack");

  property p_req_drop;
    o_mem_req.req && i_mem_rsp.ack |=> !o_mem_req.req;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("memory request held after ack");

  property p_soft_pulse;
    o_soft_int |=> !o_soft_int;
  endproperty
  a_soft_pulse: assert property (p_soft_pulse) else $error("interrupt strobe longer than one cycle");

  property p_soft_id;
    !o_soft_int |-> $stable(o_soft_int_id);
  endproperty
  a_soft_id: assert property (p_soft_id) else $error("interrupt id moved without strobe");

  // A legal block always has its end above its start, both word aligned
  property p_par_legal;
    o_par_block |-> o_par_end > o_par_start && o_par_start[1:0] == 2'h0 && o_par_end[1:0] == 2'h0;
  endproperty
  a_par_legal: assert property (p_par_legal) else $error("illegal block range accepted");

  property p_par_pulse;
    o_par_block |=> !o_par_block && $stable(o_par_start) && $stable(o_par_end);
  endproperty
  a_par_pulse: assert property (p_par_pulse) else $error("block strobe or range unstable");

  property p_fault_sticky;
    o_illegal_fault |=> o_illegal_fault && $stable(o_fault_ip);
  endproperty
  a_fault_sticky: assert property (p_fault_sticky) else $error("fault state left before reset");

  property p_fault_quiet;
    o_illegal_fault |-> !o_mem_req.req && !o_soft_int && !o_par_block;
  endproperty
  a_fault_quiet: assert property (p_fault_quiet) else $error("activity while faulted");

  c_soft: cover property (o_soft_int && o_soft_int_id == 8'h0A);
  c_par: cover property (o_par_block);
  c_fault: cover property ($rose(o_illegal_fault));
  c_write: cover property (o_mem_req.req && o_mem_req.wr && i_mem_rsp.ack);
endmodule : iex_core_sva

bind iex_core iex_core_sva iex_core_sva_i (.i_clock(i_clock), .i_rst_b(i_rst_b), .o_mem_req(o_mem_req),
  .i_mem_rsp(i_mem_rsp), .o_soft_int(o_soft_int), .o_soft_int_id(o_soft_int_id), .o_par_block(o_par_block),
  .o_par_start(o_par_start), .o_par_end(o_par_end), .o_illegal_fault(o_illegal_fault), .o_fault_ip(o_fault_ip));

// [iex_mem_model.sv]
`timescale 1ns/10ps
// ****************************************
// Instruction and data memory
// ****************************************
module iex_mem_model (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_slow,
  input wire iex_pkg::iex_mem_req_s i_mem_req,
  output iex_pkg::iex_mem_rsp_s o_mem_rsp
);
  logic [31:0] mem [logic [31:0]];
  logic [1:0] wait_r;
  logic [31:0] junk_r;

  // Read data off the ack cycle is a moving pattern, so a late sample cannot match by luck
  always @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_mem_rsp <= '0;
      wait_r <= 2'h0;
      junk_r <= 32'h5A5A_0F0F;
    end
    else
    begin
      junk_r <= junk_r + 32'h9E37_79B9;
      o_mem_rsp.ack <= 1'b0;
      o_mem_rsp.rdata <= ~junk_r;
      if (i_mem_req.req && !o_mem_rsp.ack && i_slow && wait_r != 2'h3)
        wait_r <= wait_r + 2'h1;
      else if (i_mem_req.req && !o_mem_rsp.ack)
      begin
        wait_r <= 2'h0;
        o_mem_rsp.ack <= 1'b1;
        if (i_mem_req.wr)
          mem[i_mem_req.addr] = i_mem_req.wdata;
        else if (mem.exists(i_mem_req.addr))
          o_mem_rsp.rdata <= mem[i_mem_req.addr];
      end
    end
  end
endmodule : iex_mem_model

// [iex_core_test.sv]
`timescale 1ns/10ps
// ****************************************
// Self-checking bench for the execution core
// ****************************************
module iex_core_test;
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic slow = 1'b0;
  iex_pkg::iex_mem_req_s mem_req;
  iex_pkg::iex_mem_rsp_s mem_rsp;
  logic soft_int;
  logic [7:0] soft_int_id;
  logic par_block;
  logic [31:0] par_start;
  logic [31:0] par_end;
  logic fault;
  logic [31:0] fault_ip;
  integer seed = 32'hab8b83ee;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  int par_seen = 0;
  logic [63:0] exp_q [$];
  logic [63:0] e;
  logic [31:0] v;
  logic [31:0] fprog [3][7] = '{'{32'hC, 32'h1000, 32'h1040, 32'hD, 32'hC, 32'h2000, 32'h2000},
    '{32'hC, 32'h1000, 32'h1042, 32'hE, 32'hE, 32'hE, 32'hE}, '{32'hD, 32'hE, 32'hE, 32'hE, 32'hE, 32'hE, 32'hE}};
  logic [31:0] fexp [3] = '{32'h10, 32'h0, 32'h4};

  always #5 i_clock = ~i_clock;

  iex_core iex_core_i (.i_clock(i_clock), .i_rst_b(i_rst_b), .o_mem_req(mem_req), .i_mem_rsp(mem_rsp),
    .o_soft_int(soft_int), .o_soft_int_id(soft_int_id), .o_par_block(par_block), .o_par_start(par_start),
    .o_par_end(par_end), .o_illegal_fault(fault), .o_fault_ip(fault_ip));
  iex_mem_model iex_mem_model_i (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_slow(slow), .i_mem_req(mem_req),
    .o_mem_rsp(mem_rsp));

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task load(input logic [31:0] base, input logic [31:0] w [$]);
    for (int k = 0; k < w.size(); k++)
      iex_mem_model_i.mem[base + 32'(4 * k)] = w[k];
  endtask : load

  // Reset lands mid-run on purpose: the previous program is still live
  task restart(input logic s);
    @(posedge i_clock);
    i_rst_b <= 1'b0;
    slow <= s;
    iex_mem_model_i.mem.delete();
    repeat (10) @(posedge i_clock);
  endtask : restart

  task wait_for(input bit want_fault);
    int n;
    n = 0;
    while ((want_fault ? fault : soft_int) !== 1'b1 && n < 3000)
    begin
      @(negedge i_clock);
      n++;
    end
    check("event seen", 32'(n < 3000), 32'h1);
  endtask : wait_for

  // Every memory write is held against the ordered list the program must produce
  always @(posedge i_clock)
  begin
    if (i_rst_b && mem_req.req && mem_req.wr && mem_rsp.ack)
    begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
      check("write address", mem_req.addr, e[63:32]);
      check("write data", mem_req.wdata, e[31:0]);
    end
  end

  // Only one legal block exists in the fault programs, so every strobe must carry it
  always @(posedge i_clock)
  begin
    if (i_rst_b && par_block)
    begin
      par_seen++;
      check("strobe start", par_start, 32'h1000);
      check("strobe end", par_end, 32'h1040);
    end
  end

  always @(posedge i_clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails++;
      end_of_test();
    end
  end

  initial
  begin
    for (int r = 0; r < 2; r++)
    begin
      restart(r[0]);
      v = $random(seed);
      load(32'h0, '{32'h00300002, v, 32'h00340002, 32'h200, 32'h001C0002, 32'h800, 32'h00003001, 32'h400,
        32'h00343004, 32'h00380003, 32'h400, 32'h00003801, 32'h404, 32'h7, 32'h100, 32'h00240002, 32'h0,
        32'h6, 32'h300, 32'h2, 32'h1, 32'h408, 32'h00240002, 32'h1, 32'h6, 32'h300, 32'h2, 32'hBAD, 32'h408});
      load(32'h100, '{32'hD, 32'h00383005, 32'h00002401, 32'h418, 32'h0034380A, 32'h2, 32'h77, 32'h420, 32'h8});
      load(32'h300, '{32'h002C0002, 32'hC5, 32'h00343809, 32'h00003401, 32'h414, 32'h00002C01, 32'h40C, 32'h2,
        32'hABCD, 32'h410, 32'h003C0002, 32'h404, 32'h00003C03, 32'h41C, 32'h00000A0B});
      exp_q = '{{32'h400, v}, {32'h200, v}, {32'h404, v}, {32'h800, 32'h3C}, {32'h418, 32'h1}, {32'h420, 32'h77},
        {32'h408, 32'h1}, {32'h414, (32'h200 & v) * v}, {32'h40C, 32'h5}, {32'h410, 32'hABCD}, {32'h41C, v}};
      i_rst_b <= 1'b1;
      wait_for(1'b0);
      check("interrupt id", {24'h0, soft_int_id}, 32'h0A);
      check("writes left", 32'(exp_q.size()), 32'h0);
    end
    for (int f = 0; f < 3; f++)
    begin
      restart(f[0]);
      for (int k = 0; k < 7; k++)
        iex_mem_model_i.mem[32'(4 * k)] = fprog[f][k];
      i_rst_b <= 1'b1;
      wait_for(1'b1);
      check("fault address", fault_ip, fexp[f]);
      // The refused range still lands on the range outputs, with no strobe
      check("block start", par_start, (f == 0) ? 32'h2000 : (f == 1) ? 32'h1000 : 32'h0);
      check("block end", par_end, (f == 0) ? 32'h2000 : (f == 1) ? 32'h1042 : 32'h0);
    end
    check("block strobes", 32'(par_seen), 32'h1);
    end_of_test();
  end
endmodule : iex_core_test
